/* File: mau_chk.sv */
// Port checker of the multiply accumulate unit.
// Assumes binding to mau_top; one clock, asynchronous active-low reset.
module mau_chk
  import mau_pkg::*;
(
  input wire logic              I_CLK,
  input wire logic              I_RESETN,
  input wire logic              I_AWVALID,
  input wire logic              O_AWREADY,
  input wire logic              I_WVALID,
  input wire logic              O_WREADY,
  input wire logic              O_BVALID,
  input wire logic              I_BREADY,
  input wire logic              I_ARVALID,
  input wire logic              O_ARREADY,
  input wire logic [DATA_W-1:0] O_RDATA,
  input wire logic [1:0]        O_RRESP,
  input wire logic              O_RVALID,
  input wire logic              I_RREADY,
  input wire logic              O_IRQ
);
  // ----------------------------------------------------------------
  // Bus and interrupt properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RESETN);

  sequence wr_take_s;
    I_AWVALID && O_AWREADY && I_WVALID && O_WREADY;
  endsequence
  sequence wr_answer_s;
    !O_BVALID ##1 O_BVALID;
  endsequence

  wr_answer_a: assert property (wr_take_s |=> wr_answer_s)
    else $error("write response late");
  bvalid_drop_a: assert property (O_BVALID && I_BREADY |=> !O_BVALID)
    else $error("write response not released");
  rvalid_drop_a: assert property (O_RVALID && I_RREADY |=> !O_RVALID)
    else $error("read response not released");
  rd_answer_a: assert property (I_ARVALID && O_ARREADY |=> O_RVALID)
    else $error("read response late");
  ar_block_a: assert property (O_RVALID |-> !O_ARREADY)
    else $error("read address taken while busy");
  wr_block_a: assert property (O_BVALID |-> !O_AWREADY && !O_WREADY)
    else $error("write taken while response pending");
  err_zero_a: assert property (O_RVALID && O_RRESP == RESP_SLVERR |-> O_RDATA == '0)
    else $error("error read with data");
  irq_rise_a: assert property ($rose(O_IRQ) |-> O_BVALID || $past(O_BVALID) ||
    $past(O_BVALID, 2) || $past(O_BVALID, 3))
    else $error("interrupt without a write");
  irq_fall_a: assert property ($fell(O_IRQ) |-> O_BVALID)
    else $error("interrupt dropped without a write");
endmodule : mau_chk

/* File: mau_mult.sv */
// Signed operand multiplier of the multiply accumulate unit.
// Assumes the caller registers the product; purely combinational.
module mau_mult
  import mau_pkg::*;
#(
  parameter int IN_W  = OPND_W,
  parameter int OUT_W = PROD_W
) (
  input  wire logic [IN_W-1:0]  i_a,
  input  wire logic [IN_W-1:0]  i_b,
  output logic      [OUT_W-1:0] o_prod
);

  logic [OUT_W-1:0] a_ext;
  logic [OUT_W-1:0] b_ext;

  // ------------------------------------------------------------------
  // Two's complement product
  // ------------------------------------------------------------------
  always_comb begin
    a_ext  = {{(OUT_W-IN_W){i_a[IN_W-1]}}, i_a};
    b_ext  = {{(OUT_W-IN_W){i_b[IN_W-1]}}, i_b};
    o_prod = a_ext * b_ext;
  end

endmodule : mau_mult

/* File: mau_pkg.sv */
// Constants, register map and carrier types of the multiply accumulate unit.
// Assumes a 32-bit AXI4-Lite register bus and one 100 MHz system clock.
package mau_pkg;

  // ------------------------------------------------------------------
  // Bus and register map
  // ------------------------------------------------------------------
  localparam int         ADDR_W       = 8;
  localparam int         DATA_W       = 32;
  localparam int         STRB_W       = 4;
  localparam logic [7:0] OFS_CONFIG   = 8'h00;
  localparam logic [7:0] OFS_OPA      = 8'h04;
  localparam logic [7:0] OFS_OPB      = 8'h08;
  localparam logic [7:0] OFS_STATUS   = 8'h0c;
  localparam logic [7:0] OFS_ACC_LO   = 8'h10;
  localparam logic [7:0] OFS_ACC_HI   = 8'h14;
  localparam logic [7:0] OFS_ROUND    = 8'h18;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h1c;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h20;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;

  // ------------------------------------------------------------------
  // Datapath widths
  // ------------------------------------------------------------------
  localparam int OPND_W   = 16;
  localparam int PROD_W   = 32;
  localparam int ACC_W    = 40;
  localparam int RND_W    = 16;
  localparam int GUARD_W  = ACC_W - PROD_W;
  localparam int SOFT_MSB = 31;
  localparam int RND_LSB  = 16;

  // ------------------------------------------------------------------
  // Rounding constants
  // ------------------------------------------------------------------
  localparam logic [ACC_W-1:0] RND_BIAS = 40'h00_0000_8000;
  localparam logic [RND_W-1:0] SAT_POS  = 16'h7fff;
  localparam logic [RND_W-1:0] SAT_NEG  = 16'h8000;

  // ------------------------------------------------------------------
  // Interrupt events
  // ------------------------------------------------------------------
  localparam int IRQ_W          = 3;
  localparam int IRQ_OP_DONE    = 0;
  localparam int IRQ_HI_OVF     = 1;
  localparam int IRQ_SHIFT_DONE = 2;

  // ------------------------------------------------------------------
  // Carrier types
  // ------------------------------------------------------------------
  typedef struct packed {
    logic shift_cmd;
    logic shift_dir;
    logic clr_acc;
    logic rsv;
    logic sat_en;
    logic mult_only;
  } mau_cfg_s;

  typedef struct packed {
    logic high_ovf;
    logic soft_ovf;
    logic negative;
    logic zero;
  } mau_flags_s;

  localparam int         CFG_W       = $bits(mau_cfg_s);
  localparam int         FLAGS_W     = $bits(mau_flags_s);
  localparam mau_cfg_s   CFG_RESET   = '0;
  localparam mau_flags_s FLAGS_RESET = '0;

endpackage : mau_pkg

/* File: mau_round.sv */
// Rounding and optional saturation of the accumulator to 16 bits.
// Assumes the caller registers the result; purely combinational.
module mau_round
  import mau_pkg::*;
(
  input  wire logic [ACC_W-1:0] i_acc,
  input  wire logic             i_sat_en,
  output logic      [RND_W-1:0] o_rnd
);

  logic [ACC_W-1:0] biased;
  logic             out_range;

  // ------------------------------------------------------------------
  // Round half up, clamp when enabled
  // ------------------------------------------------------------------
  always_comb begin
    biased    = i_acc + RND_BIAS;
    out_range = ~((&biased[ACC_W-1:SOFT_MSB]) | ~(|biased[ACC_W-1:SOFT_MSB]));
    if (i_sat_en && out_range) begin
      o_rnd = i_acc[ACC_W-1] ? SAT_NEG : SAT_POS;
    end else begin
      o_rnd = biased[SOFT_MSB:RND_LSB];
    end
  end

endmodule : mau_round

/* File: mau_tb_top.sv */
// Self-checking bench of the multiply accumulate unit through its register bus.
// Assumes mau_top with an AXI4-Lite slave; the checker is bound at the foot.
module mau_tb_top
  import mau_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Signals and instance
  // ----------------------------------------------------------------
  logic              clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic              awready, wready, bvalid, arready, rvalid, irq;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [DATA_W-1:0] wdata, rdata, o_rdata;
  logic [STRB_W-1:0] wstrb;
  logic [1:0]        bresp, rresp, o_bresp, o_rresp;
  int                n_fail, total_checks, cycles;

  mau_top DUT (
    .I_CLK(clk), .I_RESETN(rst_n), .I_AWADDR(awaddr), .I_AWVALID(awvalid),
    .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(wstrb), .I_WVALID(wvalid),
    .O_WREADY(wready), .O_BRESP(o_bresp), .O_BVALID(bvalid), .I_BREADY(bready),
    .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready), .O_RDATA(o_rdata),
    .O_RRESP(o_rresp), .O_RVALID(rvalid), .I_RREADY(rready), .O_IRQ(irq)
  );

  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic ta, tw, tb;
    tb = 1'h0;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    while (!tb) begin
      @(negedge clk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bready & bvalid;
      bresp = o_bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'h0;
      if (tw) wvalid <= 1'h0;
      if (tb) bready <= 1'h0;
    end
  endtask : wr

  task automatic rd(input logic [7:0] a);
    logic ta, tr;
    tr = 1'h0;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'h1;
    rready  <= 1'h1;
    while (!tr) begin
      @(negedge clk);
      ta = arvalid & arready;
      tr = rready & rvalid;
      rdata = o_rdata;
      rresp = o_rresp;
      @(posedge clk);
      if (ta) arvalid <= 1'h0;
      if (tr) rready <= 1'h0;
    end
  endtask : rd

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk($sformatf("reg %h", a), e, rdata);
  endtask : rc

  task automatic op(input logic [15:0] a, input logic [15:0] b);
    wr(OFS_OPA, {16'h0000, a}, 4'h3);
    wr(OFS_OPB, {16'h0000, b}, 4'h3);
    repeat (4) @(posedge clk);
  endtask : op

  task automatic cw(input logic [31:0] d);
    wr(OFS_CONFIG, d, 4'h1);
    repeat (3) @(posedge clk);
  endtask : cw

  task automatic print_verdict();
    if (n_fail == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict

  // ----------------------------------------------------------------
  // Clock, reset and timeout
  // ----------------------------------------------------------------
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_fail++;
      print_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, rst_n} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    {n_fail, total_checks, cycles} = '0;
    repeat (8) @(posedge clk);
    rst_n <= 1'h1;
    for (int i = 0; i <= 32; i += 4) rc(8'(i), 32'h0000_0000);
    rd(8'h24);
    chk("rd resp", 32'(RESP_SLVERR), 32'(rresp));
    wr(8'h24, 32'hffff_ffff, 4'hf);
    chk("wr resp", 32'(RESP_SLVERR), 32'(bresp));
    wr(OFS_ACC_LO, 32'h1234_5678, 4'hf);
    chk("ro resp", 32'(RESP_OKAY), 32'(bresp));
    wr(OFS_OPA, 32'h0000_0003, 4'h3);
    wr(OFS_OPB, 32'h0000_0000, 4'h2);
    repeat (4) @(posedge clk);
    rc(OFS_ACC_LO, 32'h0000_0000);
    rc(OFS_IRQ_STAT, 32'h0000_0000);
    wr(OFS_OPB, 32'h0000_0005, 4'h1);
    repeat (4) @(posedge clk);
    rc(OFS_ACC_LO, 32'h0000_000f);
    op(16'hfffe, 16'h0007);
    rc(OFS_ACC_LO, 32'h0000_0001);
    op(16'hffff, 16'h0003);
    rc(OFS_ACC_LO, 32'hffff_fffe);
    rc(OFS_ACC_HI, 32'h0000_00ff);
    rc(OFS_STATUS, 32'h0000_0002);
    cw(32'h0000_0001);
    wr(OFS_OPA, 32'h0000_0006, 4'h3);
    wr(OFS_OPB, 32'h0000_4000, 4'h3);
    rc(OFS_ACC_LO, 32'h0001_8000);
    rc(OFS_ACC_HI, 32'h0000_0000);
    rc(OFS_ROUND, 32'h0000_0002);
    rc(OFS_STATUS, 32'h0000_0000);
    cw(32'h0000_000a);
    op(16'hc000, 16'h4000);
    rc(OFS_ACC_LO, 32'hf000_0000);
    rc(OFS_CONFIG, 32'h0000_0002);
    for (int i = 0; i < 11; i++) cw(32'h0000_0022);
    rc(OFS_ACC_HI, 32'h0000_0080);
    rc(OFS_STATUS, 32'h0000_0002);
    rc(OFS_ROUND, 32'h0000_8000);
    cw(32'h0000_0032);
    rc(OFS_ACC_HI, 32'h0000_00c0);
    rc(OFS_CONFIG, 32'h0000_0012);
    cw(32'h0000_0022);
    rc(OFS_ACC_HI, 32'h0000_0080);
    op(16'hffff, 16'h0001);
    rc(OFS_ACC_HI, 32'h0000_007f);
    rc(OFS_STATUS, 32'h0000_000c);
    rc(OFS_ROUND, 32'h0000_7fff);
    cw(32'h0000_0003);
    op(16'h0002, 16'h0003);
    rc(OFS_STATUS, 32'h0000_000c);
    rc(OFS_IRQ_STAT, 32'h0000_0007);
    chk("irq", 32'h0000_0000, 32'(irq));
    wr(OFS_IRQ_MASK, 32'h0000_0002, 4'h1);
    chk("irq", 32'h0000_0001, 32'(irq));
    wr(OFS_IRQ_STAT, 32'h0000_0002, 4'h1);
    chk("irq", 32'h0000_0000, 32'(irq));
    rc(OFS_IRQ_STAT, 32'h0000_0005);
    wr(OFS_IRQ_MASK, 32'h0000_0001, 4'h1);
    chk("irq", 32'h0000_0001, 32'(irq));
    wr(OFS_IRQ_STAT, 32'h0000_0007, 4'h1);
    chk("irq", 32'h0000_0000, 32'(irq));
    cw(32'h0000_0008);
    op(16'h0002, 16'h0003);
    rc(OFS_STATUS, 32'h0000_0000);
    rc(OFS_CONFIG, 32'h0000_0000);
    wr(OFS_OPB, 32'h0000_0003, 4'h1);
    wr(OFS_OPB, 32'h0000_0003, 4'h1);
    repeat (4) @(posedge clk);
    rc(OFS_ACC_LO, 32'h0000_0012);
    print_verdict();
  end
endmodule : mau_tb_top

bind mau_top mau_chk u_chk (.*);

/* File: mau_top.sv */
// Multiply accumulate unit: AXI4-Lite registers, three-stage pipeline,
// accumulator shift, flags and a masked level interrupt.
// Assumes one clock and an asynchronous active-low reset.
//
// Overview of operation
// - Config bit 0 low selects accumulate mode, high selects multiply-only.
// - Accumulate mode adds the signed A times B product to the 40-bit accumulator.
// - Only a write to the low byte of operand B starts an operation.
// - Three pipeline stages of one cycle each; multiply in the first cycle.
// - Stage two adds the product and stores the sum into the accumulator.
// - Status flags update at the end of stage two.
// - A new start may be taken while stage two of the last one runs.
// - Rounded, optionally saturated, result lands in the round register after stage three.
// - Clear bit at start zeroes accumulator and flags next cycle, then self-clears.
// - Multiply-only overwrites the accumulator; product readable two cycles after start.
// - Multiply-only mode leaves the high overflow flag untouched.
// - Shift command shifts in one cycle, round one cycle later, command self-clears.
// - Shift direction low shifts left, high shifts right.
// - Right shift fills the top bit with accumulator bit 39.
// - Shifts leave every status flag unchanged.
//
// Decided for this implementation: the AXI4-Lite slave port and the address map.
module mau_top
  import mau_pkg::*;
(
  input  wire logic              I_CLK,
  input  wire logic              I_RESETN,
  input  wire logic [ADDR_W-1:0] I_AWADDR,
  input  wire logic              I_AWVALID,
  output logic                   O_AWREADY,
  input  wire logic [DATA_W-1:0] I_WDATA,
  input  wire logic [STRB_W-1:0] I_WSTRB,
  input  wire logic              I_WVALID,
  output logic                   O_WREADY,
  output logic      [1:0]        O_BRESP,
  output logic                   O_BVALID,
  input  wire logic              I_BREADY,
  input  wire logic [ADDR_W-1:0] I_ARADDR,
  input  wire logic              I_ARVALID,
  output logic                   O_ARREADY,
  output logic      [DATA_W-1:0] O_RDATA,
  output logic      [1:0]        O_RRESP,
  output logic                   O_RVALID,
  input  wire logic              I_RREADY,
  output logic                   O_IRQ
);

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  logic                aw_full_reg, aw_full_next;
  logic [ADDR_W-1:0]   aw_addr_reg, aw_addr_next;
  logic                w_full_reg,  w_full_next;
  logic [DATA_W-1:0]   w_data_reg,  w_data_next;
  logic [STRB_W-1:0]   w_strb_reg,  w_strb_next;
  logic                bvalid_reg,  bvalid_next;
  logic [1:0]          bresp_reg,   bresp_next;
  logic                rvalid_reg,  rvalid_next;
  logic [DATA_W-1:0]   rdata_reg,   rdata_next;
  logic [1:0]          rresp_reg,   rresp_next;

  mau_cfg_s            cfg_reg,     cfg_next;
  mau_flags_s          flags_reg,   flags_next;
  logic [OPND_W-1:0]   opa_reg,     opa_next;
  logic [OPND_W-1:0]   opb_reg,     opb_next;
  logic                st_reg,      st_next;
  logic                st_mo_reg,   st_mo_next;
  logic                st_clr_reg,  st_clr_next;
  logic                s1_reg,      s1_next;
  logic                s1_mo_reg,   s1_mo_next;
  logic [PROD_W-1:0]   prod_reg,    prod_next;
  logic [ACC_W-1:0]    acc_reg,     acc_next;
  logic                rupd_reg,    rupd_next;
  logic [RND_W-1:0]    rnd_reg,     rnd_next;
  logic [IRQ_W-1:0]    istat_reg,   istat_next;
  logic [IRQ_W-1:0]    imask_reg,   imask_next;

  logic [ADDR_W-1:0]   wa;
  logic                do_wr;
  logic                wr_hit;
  logic [DATA_W-1:0]   rd_data;
  logic                rd_hit;
  logic [PROD_W-1:0]   prod_comb;
  logic [RND_W-1:0]    rnd_comb;
  logic [ACC_W:0]      sum_w;
  logic [ACC_W-1:0]    sum;
  logic                hov;
  logic                clr_now;
  logic                shift_go;
  logic [IRQ_W-1:0]    ev;

  // ------------------------------------------------------------------
  // Arithmetic helpers
  // ------------------------------------------------------------------
  mau_mult #(
    .IN_W  (OPND_W),
    .OUT_W (PROD_W)
  ) u_mult (
    .i_a    (opa_reg),
    .i_b    (opb_reg),
    .o_prod (prod_comb)
  );

  mau_round u_round (
    .i_acc    (acc_reg),
    .i_sat_en (cfg_reg.sat_en),
    .o_rnd    (rnd_comb)
  );

  // ------------------------------------------------------------------
  // Bus handshake
  // ------------------------------------------------------------------
  assign O_AWREADY = ~aw_full_reg & ~bvalid_reg;
  assign O_WREADY  = ~w_full_reg & ~bvalid_reg;
  assign O_ARREADY = ~rvalid_reg;
  assign O_BVALID  = bvalid_reg;
  assign O_BRESP   = bresp_reg;
  assign O_RVALID  = rvalid_reg;
  assign O_RDATA   = rdata_reg;
  assign O_RRESP   = rresp_reg;
  assign O_IRQ     = |(istat_reg & imask_reg);

  assign wa    = {aw_addr_reg[ADDR_W-1:2], 2'b00};
  assign do_wr = aw_full_reg & w_full_reg & ~bvalid_reg;

  always_comb begin
    case (wa)
      OFS_CONFIG, OFS_OPA, OFS_OPB, OFS_STATUS, OFS_ACC_LO,
      OFS_ACC_HI, OFS_ROUND, OFS_IRQ_STAT, OFS_IRQ_MASK: begin
        wr_hit = 1'b1;
      end
      default: begin
        wr_hit = 1'b0;
      end
    endcase
  end

  always_comb begin
    rd_hit  = 1'b1;
    rd_data = '0;
    case ({I_ARADDR[ADDR_W-1:2], 2'b00})
      OFS_CONFIG:   rd_data = DATA_W'(cfg_reg);
      OFS_OPA:      rd_data = DATA_W'(opa_reg);
      OFS_OPB:      rd_data = DATA_W'(opb_reg);
      OFS_STATUS:   rd_data = DATA_W'(flags_reg);
      OFS_ACC_LO:   rd_data = acc_reg[DATA_W-1:0];
      OFS_ACC_HI:   rd_data = DATA_W'(acc_reg[ACC_W-1:DATA_W]);
      OFS_ROUND:    rd_data = DATA_W'(rnd_reg);
      OFS_IRQ_STAT: rd_data = DATA_W'(istat_reg);
      OFS_IRQ_MASK: rd_data = DATA_W'(imask_reg);
      default:      rd_hit  = 1'b0;
    endcase
  end

  always_comb begin
    aw_full_next = aw_full_reg;
    aw_addr_next = aw_addr_reg;
    w_full_next  = w_full_reg;
    w_data_next  = w_data_reg;
    w_strb_next  = w_strb_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    rvalid_next  = rvalid_reg;
    rdata_next   = rdata_reg;
    rresp_next   = rresp_reg;
    if (I_AWVALID && O_AWREADY) begin
      aw_full_next = 1'b1;
      aw_addr_next = I_AWADDR;
    end
    if (I_WVALID && O_WREADY) begin
      w_full_next = 1'b1;
      w_data_next = I_WDATA;
      w_strb_next = I_WSTRB;
    end
    if (do_wr) begin
      aw_full_next = 1'b0;
      w_full_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_reg && I_BREADY) begin
      bvalid_next = 1'b0;
    end
    if (I_ARVALID && O_ARREADY) begin
      rvalid_next = 1'b1;
      rdata_next  = rd_data;
      rresp_next  = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_reg && I_RREADY) begin
      rvalid_next = 1'b0;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_full_reg  <= 1'b0;
      w_data_reg  <= '0;
      w_strb_reg  <= '0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= '0;
      rresp_reg   <= RESP_OKAY;
    end else begin
      aw_full_reg <= aw_full_next;
      aw_addr_reg <= aw_addr_next;
      w_full_reg  <= w_full_next;
      w_data_reg  <= w_data_next;
      w_strb_reg  <= w_strb_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
    end
  end

  // ------------------------------------------------------------------
  // Stage two sum and flags
  // ------------------------------------------------------------------
  always_comb begin
    if (s1_mo_reg) begin
      sum_w = {{(GUARD_W+1){prod_reg[PROD_W-1]}}, prod_reg};
    end else begin
      sum_w = {acc_reg[ACC_W-1], acc_reg}
            + {{(GUARD_W+1){prod_reg[PROD_W-1]}}, prod_reg};
    end
    sum = sum_w[ACC_W-1:0];
    hov = ~s1_mo_reg & (sum_w[ACC_W] ^ sum_w[ACC_W-1]);
  end

  assign clr_now  = st_reg & st_clr_reg;
  assign shift_go = cfg_reg.shift_cmd & ~s1_reg & ~clr_now;

  // ------------------------------------------------------------------
  // Configuration, operands and pipeline
  // ------------------------------------------------------------------
  always_comb begin
    cfg_next    = cfg_reg;
    opa_next    = opa_reg;
    opb_next    = opb_reg;
    flags_next  = flags_reg;
    acc_next    = acc_reg;
    prod_next   = prod_reg;
    rnd_next    = rnd_reg;
    imask_next  = imask_reg;
    ev          = '0;
    st_next     = 1'b0;
    st_mo_next  = st_mo_reg;
    st_clr_next = st_clr_reg;
    s1_next     = st_reg;
    s1_mo_next  = st_mo_reg;
    rupd_next   = 1'b0;
    if (st_reg) begin
      prod_next = prod_comb;
    end
    if (s1_reg) begin
      acc_next             = sum;
      flags_next.zero      = ~(|sum);
      flags_next.negative  = sum[ACC_W-1];
      flags_next.soft_ovf  = flags_reg.soft_ovf
                           | ~((&sum[ACC_W-1:SOFT_MSB]) | ~(|sum[ACC_W-1:SOFT_MSB]));
      if (!s1_mo_reg) begin
        flags_next.high_ovf = flags_reg.high_ovf | hov;
      end
      rupd_next             = 1'b1;
      ev[IRQ_OP_DONE]       = 1'b1;
      ev[IRQ_HI_OVF]        = hov;
    end
    if (clr_now) begin
      acc_next         = '0;
      flags_next       = FLAGS_RESET;
      cfg_next.clr_acc = 1'b0;
    end
    if (shift_go) begin
      if (cfg_reg.shift_dir) begin
        acc_next = {acc_reg[ACC_W-1], acc_reg[ACC_W-1:1]};
      end else begin
        acc_next = {acc_reg[ACC_W-2:0], 1'b0};
      end
      cfg_next.shift_cmd  = 1'b0;
      rupd_next           = 1'b1;
      ev[IRQ_SHIFT_DONE]  = 1'b1;
    end
    if (rupd_reg) begin
      rnd_next = rnd_comb;
    end
    if (do_wr && wa == OFS_CONFIG && w_strb_reg[0]) begin
      cfg_next     = mau_cfg_s'(w_data_reg[CFG_W-1:0]);
      cfg_next.rsv = 1'b0;
    end
    if (do_wr && wa == OFS_OPA) begin
      if (w_strb_reg[0]) opa_next[7:0]  = w_data_reg[7:0];
      if (w_strb_reg[1]) opa_next[15:8] = w_data_reg[15:8];
    end
    if (do_wr && wa == OFS_OPB) begin
      if (w_strb_reg[1]) opb_next[15:8] = w_data_reg[15:8];
      if (w_strb_reg[0]) begin
        opb_next[7:0] = w_data_reg[7:0];
        st_next       = 1'b1;
        st_mo_next    = cfg_reg.mult_only;
        st_clr_next   = cfg_reg.clr_acc;
      end
    end
    if (do_wr && wa == OFS_IRQ_MASK && w_strb_reg[0]) begin
      imask_next = w_data_reg[IRQ_W-1:0];
    end
  end

  // ------------------------------------------------------------------
  // Sticky interrupt status, set wins over clear
  // ------------------------------------------------------------------
  always_comb begin
    istat_next = istat_reg;
    if (do_wr && wa == OFS_IRQ_STAT && w_strb_reg[0]) begin
      istat_next = istat_reg & ~w_data_reg[IRQ_W-1:0];
    end
    istat_next = istat_next | ev;
  end

  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      cfg_reg    <= CFG_RESET;
      flags_reg  <= FLAGS_RESET;
      opa_reg    <= '0;
      opb_reg    <= '0;
      st_reg     <= 1'b0;
      st_mo_reg  <= 1'b0;
      st_clr_reg <= 1'b0;
      s1_reg     <= 1'b0;
      s1_mo_reg  <= 1'b0;
      prod_reg   <= '0;
      acc_reg    <= '0;
      rupd_reg   <= 1'b0;
      rnd_reg    <= '0;
      istat_reg  <= '0;
      imask_reg  <= '0;
    end else begin
      cfg_reg    <= cfg_next;
      flags_reg  <= flags_next;
      opa_reg    <= opa_next;
      opb_reg    <= opb_next;
      st_reg     <= st_next;
      st_mo_reg  <= st_mo_next;
      st_clr_reg <= st_clr_next;
      s1_reg     <= s1_next;
      s1_mo_reg  <= s1_mo_next;
      prod_reg   <= prod_next;
      acc_reg    <= acc_next;
      rupd_reg   <= rupd_next;
      rnd_reg    <= rnd_next;
      istat_reg  <= istat_next;
      imask_reg  <= imask_next;
    end
  end

endmodule : mau_top
